// *** hw/spoc_monitor.sv ***
// single-phase overcurrent, thermal alert and droop compensation logic
module spoc_monitor (
    input  wire logic                             mclk,
    input  wire logic                             rst,
    input  wire logic [spoc_pkg::CODE_W-1:0]      perPhaseInfo,
    input  wire logic [spoc_pkg::CODE_W-1:0]      singleCurrentMonitorPin,
    input  wire logic [spoc_pkg::CODE_W-1:0]      thermistorSenseInput0,
    input  wire logic [spoc_pkg::CODE_W-1:0]      thermistorSenseInput1,
    input  wire logic [spoc_pkg::CODE_W-1:0]      thermalCompGainInput0,
    input  wire logic [spoc_pkg::CODE_W-1:0]      thermalCompGainInput1,
    input  wire logic [spoc_pkg::TEMP_W-1:0]      tempLimitSetting,
    input  wire logic [spoc_pkg::CODE_W-1:0]      positioningCurrentIn0,
    input  wire logic [spoc_pkg::CODE_W-1:0]      positioningCurrentIn1,
    input  wire logic                             pwmLowReq,
    input  wire logic                             pwmHighReq,
    output logic                                  lowSideSwitch,
    output logic                                  highSideSwitch,
    output logic                                  driveEnable,
    output logic                                  multiDriveEnable,
    output logic [spoc_pkg::CODE_W-1:0]           perPhaseCurrentClamped,
    output logic                                  singleMaxCurrentPoint,
    output logic                                  totalFault,
    output logic [spoc_pkg::TEMP_W-1:0]           reportedTemp0,
    output logic [spoc_pkg::TEMP_W-1:0]           reportedTemp1,
    output logic                                  overtempAlert0N,
    output logic                                  overtempAlert1N,
    output logic [spoc_pkg::CORR_W-1:0]           positioningCurrent0,
    output logic [spoc_pkg::CORR_W-1:0]           positioningCurrent1
);
    import spoc_pkg::*;

    function automatic logic [CODE_W-1:0] clampCode(input logic [CODE_W-1:0] v,
                                                    input logic [CODE_W-1:0] lim);
        clampCode = (v > lim) ? lim : v;
    endfunction

    function automatic logic [CORR_W-1:0] compensate(input logic [CODE_W-1:0] droop,
                                                     input logic [CODE_W-1:0] sense,
                                                     input logic [CODE_W-1:0] gain);
        logic [CODE_W:0] diff;
        logic [CODE_W+1:0] sum;
        diff = '0;
        sum = '0;
        if (gain <= COMP_GROUND_MV) begin
            compensate = droop;
        end else begin
            // hotter thermistor reads lower than the gain level; raise droop to match
            diff = (gain > sense) ? {1'b0, gain - sense} : '0;
            sum = {1'b0, droop} + (CODE_W+2)'(diff[CODE_W:3]);
            compensate = (sum > (CODE_W+2)'(12'hFFF)) ? 12'hFFF : sum[CORR_W-1:0];
        end
    endfunction

    // three-stage synchronisers for the comparator levels
    logic [2:0] perOcSync_q;
    logic [2:0] totOcSync_q;
    logic [2:0] maxSync_q;
    logic       perOc_q;
    logic       totOc_q;
    logic       maxPt_q;
    logic       perOcRaw;
    logic       totOcRaw;
    logic       maxRaw;

    assign perOcRaw = perPhaseInfo > PER_PHASE_TRIP_NA;
    assign totOcRaw = singleCurrentMonitorPin >= TOTAL_TRIP_MV;
    assign maxRaw   = singleCurrentMonitorPin >= MAX_POINT_MV;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            perOcSync_q <= '0;
            totOcSync_q <= '0;
            maxSync_q   <= '0;
        end else begin
            perOcSync_q <= {perOcSync_q[1:0], perOcRaw};
            totOcSync_q <= {totOcSync_q[1:0], totOcRaw};
            maxSync_q   <= {maxSync_q[1:0], maxRaw};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            perOc_q <= 1'b0;
            totOc_q <= 1'b0;
            maxPt_q <= 1'b0;
        end else begin
            if (perOcSync_q[1] == perOcSync_q[2]) begin
                perOc_q <= perOcSync_q[2];
            end
            if (totOcSync_q[1] == totOcSync_q[2]) begin
                totOc_q <= totOcSync_q[2];
            end
            if (maxSync_q[1] == maxSync_q[2]) begin
                maxPt_q <= maxSync_q[2];
            end
        end
    end

    // latched total-current fault
    spoc_fault_t fault_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_q <= SPOC_RUN;
        end else begin
            unique case (fault_q)
                SPOC_RUN: begin
                    if (totOc_q) begin
                        fault_q <= SPOC_LATCHED;
                    end
                end
                SPOC_LATCHED: begin
                    fault_q <= SPOC_LATCHED;
                end
            endcase
        end
    end

    logic faultNow;
    assign faultNow = (fault_q == SPOC_LATCHED) || totOc_q;

    // switch drive
    logic lowSide_q;
    logic highSide_q;
    logic drvEn_q;
    logic multiEn_q;
    logic [CODE_W-1:0] clamp_q;
    logic maxOut_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lowSide_q  <= 1'b0;
            highSide_q <= 1'b0;
            drvEn_q    <= 1'b0;
            multiEn_q  <= 1'b0;
        end else if (faultNow) begin
            lowSide_q  <= 1'b0;
            highSide_q <= 1'b0;
            drvEn_q    <= 1'b0;
            multiEn_q  <= 1'b0;
        end else if (perOc_q) begin
            lowSide_q  <= 1'b1;
            highSide_q <= 1'b0;
            drvEn_q    <= 1'b1;
            multiEn_q  <= 1'b1;
        end else begin
            lowSide_q  <= pwmLowReq & ~pwmHighReq;
            highSide_q <= pwmHighReq;
            drvEn_q    <= 1'b1;
            multiEn_q  <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clamp_q  <= '0;
            maxOut_q <= 1'b0;
        end else begin
            clamp_q  <= clampCode(perPhaseInfo, PER_PHASE_TRIP_NA);
            maxOut_q <= maxPt_q;
        end
    end

    // thermistor conversion, alternating between the two sensors
    spoc_tbl_if tbl ();
    spoc_temp_table uTable (
        .mclk (mclk),
        .rst  (rst),
        .tbl  (tbl)
    );

    logic                sel_q;
    logic                selD_q;
    logic [TEMP_W-1:0]   temp0_q;
    logic [TEMP_W-1:0]   temp1_q;
    logic [1:0]          valid_q;
    assign tbl.addr = sel_q ? thermistorSenseInput1[CODE_W-1 -: TBL_AW]
                            : thermistorSenseInput0[CODE_W-1 -: TBL_AW];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sel_q   <= 1'b0;
            selD_q  <= 1'b0;
            temp0_q <= '0;
            temp1_q <= '0;
            valid_q <= '0;
        end else begin
            sel_q  <= ~sel_q;
            selD_q <= sel_q;
            if (selD_q) begin
                temp1_q    <= tbl.data;
                valid_q[1] <= 1'b1;
            end else begin
                temp0_q    <= tbl.data;
                valid_q[0] <= 1'b1;
            end
        end
    end

    // over-temperature alert per section
    logic alert0_q;
    logic alert1_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alert0_q <= 1'b0;
            alert1_q <= 1'b0;
        end else begin
            alert0_q <= valid_q[0] && (temp0_q > tempLimitSetting);
            alert1_q <= valid_q[1] && (temp1_q > tempLimitSetting);
        end
    end

    // droop compensation per section
    logic [CORR_W-1:0] droop0_q;
    logic [CORR_W-1:0] droop1_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            droop0_q <= '0;
            droop1_q <= '0;
        end else begin
            droop0_q <= compensate(positioningCurrentIn0, thermistorSenseInput0,
                                   thermalCompGainInput0);
            droop1_q <= compensate(positioningCurrentIn1, thermistorSenseInput1,
                                   thermalCompGainInput1);
        end
    end

    assign lowSideSwitch          = lowSide_q;
    assign highSideSwitch         = highSide_q;
    assign driveEnable            = drvEn_q;
    assign multiDriveEnable       = multiEn_q;
    assign perPhaseCurrentClamped = clamp_q;
    assign singleMaxCurrentPoint  = maxOut_q;
    assign totalFault             = fault_q == SPOC_LATCHED;
    assign reportedTemp0          = temp0_q;
    assign reportedTemp1          = temp1_q;
    assign overtempAlert0N        = ~alert0_q;
    assign overtempAlert1N        = ~alert1_q;
    assign positioningCurrent0    = droop0_q;
    assign positioningCurrent1    = droop1_q;
endmodule

// *** common/spoc_pkg.sv ***
// package: thresholds, widths and table size for the single-phase protection block
package spoc_pkg;
    // digitized sense values: volts in millivolt codes, currents in 10 nA codes
    localparam int CODE_W = 12;
    localparam logic [CODE_W-1:0] PER_PHASE_TRIP_NA  = 12'hDAC; // 35 uA, 3500 x 10 nA
    localparam logic [CODE_W-1:0] TOTAL_TRIP_MV      = 12'h60E; // 1.55 V
    localparam logic [CODE_W-1:0] MAX_POINT_MV       = 12'h4D8; // 1.24 V
    localparam logic [CODE_W-1:0] COMP_GROUND_MV     = 12'h032; // gain input seen as ground
    localparam int SECTIONS = 2;
    localparam int TEMP_W   = 8;
    localparam int CORR_W   = 12;
    // thermistor conversion table address width (2**TBL_AW entries)
    localparam int TBL_AW   = 6;
    typedef enum logic [0:0] {SPOC_RUN, SPOC_LATCHED} spoc_fault_t;
endpackage

// *** common/spoc_tbl_if.sv ***
// interface: thermistor conversion table lookup
interface spoc_tbl_if;
    import spoc_pkg::*;
    logic [TBL_AW-1:0] addr;
    logic [TEMP_W-1:0] data;
    modport user  (output addr, input data);
    modport table_side (input addr, output data);
endinterface

// *** hw/spoc_temp_table.sv ***
// registered conversion table from thermistor voltage code to temperature
module spoc_temp_table (
    input  wire logic   mclk,
    input  wire logic   rst,
    spoc_tbl_if.table_side tbl
);
    import spoc_pkg::*;
    logic [TEMP_W-1:0] rom [2**TBL_AW];
    logic [TEMP_W-1:0] data_q;

    // higher voltage means cooler thermistor; linear default curve
    always_comb begin
        for (int i = 0; i < 2**TBL_AW; i++) begin
            rom[i] = TEMP_W'(8'h96 - 8'(i * 2));
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            data_q <= '0;
        end else begin
            data_q <= rom[tbl.addr];
        end
    end

    assign tbl.data = data_q;
endmodule

// *** test/spoc_stage_model.sv ***
// power stage and sense network model feeding the protection block
module spoc_stage_model (
    input  wire logic        mclk,
    input  wire logic [11:0] phaseLoad,
    input  wire logic [11:0] totalLoad,
    input  wire logic        driveEnable,
    output logic      [11:0] infoCode,
    output logic      [11:0] pinCode
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        infoCode = 12'h000;
        pinCode = 12'h000;
    end
    // a stage in high impedance delivers no current, so both sense levels collapse
    always @(posedge mclk) begin
        infoCode <= driveEnable ? phaseLoad : 12'h000;
        pinCode <= driveEnable ? totalLoad : 12'h000;
    end
endmodule

// *** test/spoc_prot_monitor.sv ***
// checker: port properties of the single-phase protection block
module spoc_prot_monitor
    import spoc_pkg::*;
(
    input wire logic                          mclk,
    input wire logic                          rst,
    input wire logic [spoc_pkg::CODE_W-1:0]   perPhaseInfo,
    input wire logic [spoc_pkg::CODE_W-1:0]   singleCurrentMonitorPin,
    input wire logic [spoc_pkg::CODE_W-1:0]   thermistorSenseInput0,
    input wire logic [spoc_pkg::CODE_W-1:0]   thermistorSenseInput1,
    input wire logic [spoc_pkg::CODE_W-1:0]   thermalCompGainInput0,
    input wire logic [spoc_pkg::TEMP_W-1:0]   tempLimitSetting,
    input wire logic [spoc_pkg::CODE_W-1:0]   positioningCurrentIn0,
    input wire logic                          lowSideSwitch,
    input wire logic                          driveEnable,
    input wire logic                          multiDriveEnable,
    input wire logic [spoc_pkg::CODE_W-1:0]   perPhaseCurrentClamped,
    input wire logic                          singleMaxCurrentPoint,
    input wire logic                          totalFault,
    input wire logic [spoc_pkg::TEMP_W-1:0]   reportedTemp0,
    input wire logic [spoc_pkg::TEMP_W-1:0]   reportedTemp1,
    input wire logic                          overtempAlert0N,
    input wire logic                          overtempAlert1N,
    input wire logic [spoc_pkg::CORR_W-1:0]   positioningCurrent0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [12:0] sum0;
    logic [11:0] corr0;
    function automatic logic [7:0] tempOf(input logic [11:0] s);
        return 8'h96 - {1'b0, s[11:6], 1'b0};
    endfunction
    always_comb begin
        sum0 = {1'b0, positioningCurrentIn0} + 13'((thermalCompGainInput0 - thermistorSenseInput0) >> 3);
        corr0 = positioningCurrentIn0;
        if (thermalCompGainInput0 > COMP_GROUND_MV && thermalCompGainInput0 > thermistorSenseInput0)
            corr0 = sum0[12] ? 12'hFFF : sum0[11:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_clamp_value: assert property (perPhaseInfo > PER_PHASE_TRIP_NA |=>
        perPhaseCurrentClamped == PER_PHASE_TRIP_NA) else $error("clamp not at trip level");
    a_lowside_forced: assert property ((perPhaseInfo > PER_PHASE_TRIP_NA)[*6] |->
        lowSideSwitch || !driveEnable) else $error("low side not forced on");
    a_total_trip: assert property ((singleCurrentMonitorPin >= TOTAL_TRIP_MV)[*4] |->
        ##[0:4] (totalFault && !driveEnable)) else $error("total trip not latched");
    a_fault_holds: assert property (totalFault |=> totalFault)
        else $error("fault cleared without reset");
    a_fault_hiz: assert property (totalFault |-> !driveEnable && !multiDriveEnable)
        else $error("drive enabled during fault");
    a_max_point: assert property ($stable(singleCurrentMonitorPin)[*7] |->
        singleMaxCurrentPoint == (singleCurrentMonitorPin >= MAX_POINT_MV))
        else $error("max current point wrong");
    a_temp_conv: assert property ($stable({thermistorSenseInput0, thermistorSenseInput1})[*8]
        |-> reportedTemp0 == tempOf(thermistorSenseInput0)
        && reportedTemp1 == tempOf(thermistorSenseInput1)) else $error("temperature wrong");
    a_alert_follow: assert property (1'b1 |=>
        overtempAlert0N == !($past(reportedTemp0) > $past(tempLimitSetting))
        && overtempAlert1N == !($past(reportedTemp1) > $past(tempLimitSetting)))
        else $error("alert level wrong");
    a_droop_corr: assert property (1'b1 |=> positioningCurrent0 == $past(corr0))
        else $error("droop correction wrong");
    c_fault: cover property (totalFault);
    c_lowside: cover property (lowSideSwitch && driveEnable);
    c_alert: cover property (!overtempAlert0N);
    c_corr: cover property (positioningCurrent0 != positioningCurrentIn0);
endmodule

bind spoc_monitor spoc_prot_monitor chk (.*);

// *** test/spoc_monitor_test.sv ***
// self-checking bench for the single-phase protection block
module spoc_monitor_test;
    import spoc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int sel; logic [11:0] exp;} spoc_note_t;
    logic mclk = 1'b0, rst = 1'b1, pwmLowReq = 1'b0, pwmHighReq = 1'b0;
    logic [11:0] thermistorSenseInput0 = 12'h800, thermistorSenseInput1 = 12'h800;
    logic [11:0] thermalCompGainInput0 = 12'h000, thermalCompGainInput1 = 12'h000;
    logic [11:0] positioningCurrentIn0 = 12'h100, positioningCurrentIn1 = 12'h100;
    logic [11:0] phaseLoad = 12'h000, totalLoad = 12'h000;
    logic [7:0]  tempLimitSetting = 8'h50;
    logic [11:0] perPhaseInfo, singleCurrentMonitorPin, perPhaseCurrentClamped;
    logic [11:0] positioningCurrent0, positioningCurrent1;
    logic [7:0]  reportedTemp0, reportedTemp1;
    logic        lowSideSwitch, highSideSwitch, driveEnable, multiDriveEnable;
    logic        singleMaxCurrentPoint, totalFault, overtempAlert0N, overtempAlert1N;
    spoc_note_t  notes[$];
    int          n_fail = 0;
    int          checked = 0;
    int          seed = 32'h0A595F7A;

    spoc_monitor uut (.*);
    spoc_stage_model stage (.mclk(mclk), .phaseLoad(phaseLoad), .totalLoad(totalLoad),
        .driveEnable(driveEnable), .infoCode(perPhaseInfo), .pinCode(singleCurrentMonitorPin));

    initial forever #2.5 mclk = ~mclk;

    function automatic logic [11:0] seen(input int sel);
        case (sel)
            0: return perPhaseCurrentClamped;
            1: return {11'h000, lowSideSwitch};
            2: return {4'h0, reportedTemp0};
            3: return {4'h0, reportedTemp1};
            4: return {10'h000, overtempAlert1N, overtempAlert0N};
            5: return positioningCurrent0;
            6: return positioningCurrent1;
            7: return {11'h000, singleMaxCurrentPoint};
            9: return {11'h000, highSideSwitch};
            default: return {9'h000, totalFault, driveEnable, multiDriveEnable};
        endcase
    endfunction
    function automatic logic [7:0] tempOf(input logic [11:0] s);
        return 8'h96 - {1'b0, s[11:6], 1'b0};
    endfunction
    function automatic logic [11:0] droop(input logic [11:0] p, g, s);
        logic [12:0] t;
        t = {1'b0, p} + 13'((g - s) >> 3);
        if (g <= COMP_GROUND_MV || g <= s) return p;
        return t[12] ? 12'hFFF : t[11:0];
    endfunction
    task automatic check(input logic [11:0] got, want);
        checked++;
        if (got !== want) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, got, want);
        end
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic note(input int sel, input logic [11:0] exp);
        notes.push_back('{sel, exp});
    endtask

    // watcher: drains every queued note, oldest first, comparing each against the settled output it selects
    always @(negedge mclk) begin
        while (notes.size() > 0) begin
            spoc_note_t n;
            n = notes.pop_front();
            check(seen(n.sel), n.exp);
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        report_and_stop;
    end

    initial begin
        logic [11:0] s0, s1, g0, g1, p0, p1, ph, tot;
        logic [7:0]  lim;
        logic        lo, hi;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 48; i++) begin
            @(posedge mclk);
            s0 = 12'($random(seed));
            s1 = 12'($random(seed));
            g0 = (i % 4 == 0) ? COMP_GROUND_MV : 12'($random(seed));
            g1 = (i % 4 == 1) ? 12'h000 : 12'($random(seed));
            p0 = 12'($random(seed));
            p1 = 12'($random(seed));
            lim = 8'($random(seed));
            ph = 12'(PER_PHASE_TRIP_NA + i % 3 - 1);
            tot = 12'(MAX_POINT_MV + i % 2 - 1);
            thermistorSenseInput0 <= s0;
            thermistorSenseInput1 <= s1;
            thermalCompGainInput0 <= g0;
            thermalCompGainInput1 <= g1;
            positioningCurrentIn0 <= p0;
            positioningCurrentIn1 <= p1;
            tempLimitSetting <= lim;
            phaseLoad <= ph;
            totalLoad <= tot;
            lo = 1'($random(seed));
            hi = 1'($random(seed));
            pwmLowReq <= lo;
            pwmHighReq <= hi;
            repeat (10) @(posedge mclk);
            note(0, (ph > PER_PHASE_TRIP_NA) ? PER_PHASE_TRIP_NA : ph);
            note(1, 12'((ph > PER_PHASE_TRIP_NA) || (lo && !hi)));
            note(9, 12'((ph <= PER_PHASE_TRIP_NA) && hi));
            note(2, 12'(tempOf(s0)));
            note(3, 12'(tempOf(s1)));
            note(4, {10'h000, !(tempOf(s1) > lim), !(tempOf(s0) > lim)});
            note(5, droop(p0, g0, s0));
            note(6, droop(p1, g1, s1));
            note(7, 12'(tot >= MAX_POINT_MV));
        end
        @(posedge mclk);
        totalLoad <= 12'(TOTAL_TRIP_MV - 1);
        repeat (10) @(posedge mclk);
        note(8, 12'h003);
        totalLoad <= TOTAL_TRIP_MV;
        repeat (8) @(posedge mclk);
        note(8, 12'h004);
        repeat (30) @(posedge mclk);
        note(8, 12'h004);
        repeat (2) @(posedge mclk);
        report_and_stop;
    end
endmodule
